// ### hw/rre_cfg.svh
// constants for the return and rotate execute block
// assumes inclusion by bare name from design files
`ifndef RRE_CFG_SVH
`define RRE_CFG_SVH
`define RRE_OP_RETFI       14'h0009
`define RRE_OP_RETSUB      14'h0008
`define RRE_LIT_PFX_MSB    13
`define RRE_LIT_PFX_LSB    10
`define RRE_LIT_PFX        4'hD
`define RRE_ROT_PFX_MSB    13
`define RRE_ROT_PFX_LSB    8
`define RRE_ROT_PFX        6'h0D
`define RRE_DEST_BIT       7
`define RRE_IRQ_EN_BIT     7
`define RRE_RET_CYCLES     2
`define RRE_ROT_CYCLES     1
`define RRE_W_RST          8'h00
`define RRE_PC_RST         13'h0000
`endif

// ### hw/rre_pkg.sv
// types for the return and rotate execute block
// assumes rre_cfg.svh constants
package rre_pkg;
  typedef enum logic [2:0] {
    RRE_OP_NONE,
    RRE_OP_RETFI,
    RRE_OP_RETLIT,
    RRE_OP_RETSUB,
    RRE_OP_ROTL
  } rre_op_e;
endpackage : rre_pkg

// ### hw/rre_decode.sv
// opcode classifier for return and rotate instructions
// assumes a 14-bit instruction word from the same clock domain
`timescale 1ns/1ps
`default_nettype none
`include "rre_cfg.svh"
module rre_decode
  import rre_pkg::*;
(
  // instruction
  input  wire logic [13:0] instr,
  // class
  output var  rre_op_e     op
);
  always_comb
  begin
    op = RRE_OP_NONE;
    if (instr == `RRE_OP_RETFI)
      op = RRE_OP_RETFI;
    else if (instr == `RRE_OP_RETSUB)
      op = RRE_OP_RETSUB;
    else if (instr[`RRE_LIT_PFX_MSB:`RRE_LIT_PFX_LSB] == `RRE_LIT_PFX)
      op = RRE_OP_RETLIT;
    else if (instr[`RRE_ROT_PFX_MSB:`RRE_ROT_PFX_LSB] == `RRE_ROT_PFX)
      op = RRE_OP_ROTL;
  end
endmodule : rre_decode
`default_nettype wire

// ### hw/rre_exec.sv
// execute unit for return, return-with-literal, return-from-interrupt and rotate-left
// assumes stack, file bank and interrupt controller are neighbours on the same clock
// Operation
// RL1: the return-from-interrupt opcode pops the stack into the pc and sets the global enable, over two cycles.
// RL2: the return-with-literal opcode loads the literal into the accumulator and the popped top into the pc, over two cycles.
// RL3: a subroutine return pops the stack into the pc over two cycles and leaves the flags alone.
// RL4: the rotate opcode rotates the addressed register left through carry in one cycle, touching only carry.
// RL5: a destination bit of zero sends the result to the accumulator, one sends it back to the file register.
// RL6: the old carry enters result bit 0 and source bit 7 becomes the new carry.
`timescale 1ns/1ps
`default_nettype none
`include "rre_cfg.svh"
module rre_exec
  import rre_pkg::*;
#(
  parameter int PC_W = 13
)
(
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rst,
  // instruction issue
  input  wire logic            instr_valid,
  input  wire logic [13:0]     instr,
  output logic                 busy,
  output logic                 done,
  // stack
  input  wire logic [PC_W-1:0] stack_top_entry,
  output logic                 stack_pop,
  // program counter
  output logic                 pc_load,
  output logic [PC_W-1:0]      pc_value,
  // interrupt enable
  output logic                 global_irq_enable_set,
  // file register port
  output logic [6:0]           file_addr,
  input  wire logic [7:0]      file_rdata,
  output logic                 file_we,
  output logic [7:0]           file_wdata,
  // accumulator and carry
  input  wire logic            carry_in,
  output logic                 carry_we,
  output logic                 carry_out,
  output logic [7:0]           w_value,
  output logic                 w_we
);
  typedef enum logic {RRE_ST_IDLE, RRE_ST_SECOND} rre_st_e;

  // return cycle counter, loaded on take and run down in the second state
  localparam int               CNT_W    = 2;
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
  localparam logic [CNT_W-1:0] RET_LAST = CNT_W'(`RRE_RET_CYCLES - 1);

  typedef struct packed {
    rre_st_e          st;
    rre_op_e          cur;
    logic [CNT_W-1:0] cnt;
    logic             busy;
    logic             done;
    logic             pop;
    logic             pc_load;
    logic [PC_W-1:0]  pc;
    logic             irq_set;
    logic             file_we;
    logic [7:0]       fdata;
    logic             carry_we;
    logic             carry;
    logic [7:0]       w;
    logic             w_we;
  } rre_state_s;

  rre_state_s s_reg, s_next;
  rre_op_e    op;

  // return-class opcodes all pop the stack and take two cycles
  function automatic logic rre_is_return(input rre_op_e o);
    return (o == RRE_OP_RETFI) || (o == RRE_OP_RETLIT) || (o == RRE_OP_RETSUB);
  endfunction : rre_is_return

  // left rotate through carry, old carry into bit 0
  function automatic logic [7:0] rre_rotl(input logic [7:0] src, input logic cin);
    return {src[6:0], cin}; // RL6
  endfunction : rre_rotl

  // common start of every return: pop, reload pc, go busy
  function automatic rre_state_s rre_start_ret(input rre_state_s      s,
                                               input rre_op_e         o,
                                               input logic [PC_W-1:0] top);
    rre_state_s r;
    r         = s;
    r.st      = RRE_ST_SECOND;
    r.cur     = o;
    r.cnt     = RET_LAST;
    r.busy    = 1'b1;
    r.pop     = 1'b1;
    r.pc_load = 1'b1;
    r.pc      = top;
    return r;
  endfunction : rre_start_ret

  rre_decode i_rre_decode
  (
    .instr (instr),
    .op    (op)
  );

  // read address follows the issued word so read data arrives in the take cycle
  assign file_addr = instr[6:0];

  // next state: strobes last one cycle, held values stay until rewritten
  always_comb
  begin
    s_next          = s_reg;
    s_next.done     = 1'b0;
    s_next.pop      = 1'b0;
    s_next.pc_load  = 1'b0;
    s_next.irq_set  = 1'b0;
    s_next.file_we  = 1'b0;
    s_next.carry_we = 1'b0;
    s_next.w_we     = 1'b0;
    unique case (s_reg.st)
      RRE_ST_IDLE:
      begin
        if (instr_valid)
        begin
          unique case (op)
            RRE_OP_RETFI:
            begin
              s_next         = rre_start_ret(s_next, op, stack_top_entry); // RL1
              s_next.irq_set = 1'b1; // RL1
            end
            RRE_OP_RETLIT:
            begin
              s_next      = rre_start_ret(s_next, op, stack_top_entry); // RL2
              s_next.w    = instr[7:0]; // RL2
              s_next.w_we = 1'b1;
            end
            RRE_OP_RETSUB:
            begin
              s_next = rre_start_ret(s_next, op, stack_top_entry); // RL3
            end
            RRE_OP_ROTL:
            begin
              s_next.done     = 1'b1; // RL4
              s_next.carry_we = 1'b1;
              s_next.carry    = file_rdata[7]; // RL6
              if (instr[`RRE_DEST_BIT])
              begin
                s_next.file_we = 1'b1; // RL5
                s_next.fdata   = rre_rotl(file_rdata, carry_in);
              end
              else
              begin
                s_next.w_we = 1'b1; // RL5
                s_next.w    = rre_rotl(file_rdata, carry_in);
              end
            end
            default:
            begin
              s_next.st = RRE_ST_IDLE;
            end
          endcase
        end
      end
      RRE_ST_SECOND:
      begin
        // issue is ignored here; a stray class falls back to idle
        if ((s_reg.cnt == CNT_ONE) || !rre_is_return(s_reg.cur))
        begin
          s_next.st   = RRE_ST_IDLE;
          s_next.busy = 1'b0;
          s_next.cur  = RRE_OP_NONE;
          s_next.done = rre_is_return(s_reg.cur); // RL1 RL2 RL3
        end
        else
        begin
          s_next.cnt = s_reg.cnt - CNT_ONE;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_reg.st       <= RRE_ST_IDLE;
      s_reg.cur      <= RRE_OP_NONE;
      s_reg.cnt      <= '0;
      s_reg.busy     <= 1'b0;
      s_reg.done     <= 1'b0;
      s_reg.pop      <= 1'b0;
      s_reg.pc_load  <= 1'b0;
      s_reg.pc       <= PC_W'(`RRE_PC_RST);
      s_reg.irq_set  <= 1'b0;
      s_reg.file_we  <= 1'b0;
      s_reg.fdata    <= 8'h00;
      s_reg.carry_we <= 1'b0;
      s_reg.carry    <= 1'b0;
      s_reg.w        <= `RRE_W_RST;
      s_reg.w_we     <= 1'b0;
    end
    else
      s_reg <= s_next;
  end

  // issue status
  assign busy                  = s_reg.busy;
  assign done                  = s_reg.done;

  // stack, pc and interrupt enable
  assign stack_pop             = s_reg.pop;
  assign pc_load               = s_reg.pc_load;
  assign pc_value              = s_reg.pc;
  assign global_irq_enable_set = s_reg.irq_set;

  // file register write-back
  assign file_we               = s_reg.file_we;
  assign file_wdata            = s_reg.fdata;

  // carry and accumulator
  assign carry_we              = s_reg.carry_we;
  assign carry_out             = s_reg.carry;
  assign w_value               = s_reg.w;
  assign w_we                  = s_reg.w_we;
endmodule : rre_exec
`default_nettype wire

// ### sim/rre_exec_asserts.sv
// checker for rre_exec
// assumes a bind onto rre_exec
`timescale 1ns/1ps
`default_nettype none
module rre_exec_asserts
#(
  parameter int PC_W = 13
)
(
  // clock and reset
  input wire logic            clk,
  input wire logic            rst,
  // instruction issue
  input wire logic            instr_valid,
  input wire logic [13:0]     instr,
  input wire logic            busy,
  input wire logic            done,
  // stack and pc
  input wire logic [PC_W-1:0] stack_top_entry,
  input wire logic            stack_pop,
  input wire logic            pc_load,
  input wire logic [PC_W-1:0] pc_value,
  input wire logic            global_irq_enable_set,
  // file port, accumulator and carry
  input wire logic [7:0]      file_rdata,
  input wire logic            file_we,
  input wire logic [7:0]      file_wdata,
  input wire logic            carry_in,
  input wire logic            carry_we,
  input wire logic            carry_out,
  input wire logic [7:0]      w_value,
  input wire logic            w_we
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic tk;
  assign tk = instr_valid && !busy;
  retfi_irq_a: assert property (tk && instr == 14'h0009 |=> global_irq_enable_set
    && stack_pop ##1 done) else $error("return from interrupt wrong");
  retlit_w_a: assert property (tk && instr[13:10] == 4'hD |=> w_we && pc_load
    && w_value == $past(instr[7:0]) ##1 done) else $error("literal return wrong");
  retsub_pc_a: assert property (tk && instr == 14'h0008 |=> stack_pop && !carry_we
    && pc_value == $past(stack_top_entry) ##1 done) else $error("return wrong");
  rot_one_a: assert property (tk && instr[13:8] == 6'h0D |=> done && carry_we
    && carry_out == $past(file_rdata[7])) else $error("rotate carry wrong");
  rot_file_a: assert property (tk && instr[13:7] == 7'h1B |=> file_we && !w_we
    && file_wdata == {$past(file_rdata[6:0]), $past(carry_in)}) else $error("rotate to file wrong");
  rot_acc_a: assert property (tk && instr[13:7] == 7'h1A |=> w_we && !file_we
    && w_value == {$past(file_rdata[6:0]), $past(carry_in)}) else $error("rotate to acc wrong");
  busy_quiet_a: assert property (busy |=> !stack_pop && !carry_we && !file_we)
    else $error("strobe while busy");
endmodule : rre_exec_asserts
bind rre_exec rre_exec_asserts #(.PC_W(PC_W)) i_rre_exec_asserts
(
  .clk                   (clk),
  .rst                   (rst),
  .instr_valid           (instr_valid),
  .instr                 (instr),
  .busy                  (busy),
  .done                  (done),
  .stack_top_entry       (stack_top_entry),
  .stack_pop             (stack_pop),
  .pc_load               (pc_load),
  .pc_value              (pc_value),
  .global_irq_enable_set (global_irq_enable_set),
  .file_rdata            (file_rdata),
  .file_we               (file_we),
  .file_wdata            (file_wdata),
  .carry_in              (carry_in),
  .carry_we              (carry_we),
  .carry_out             (carry_out),
  .w_value               (w_value),
  .w_we                  (w_we)
);
`default_nettype wire

// ### sim/rre_exec_test.sv
// testbench for rre_exec
// assumes the design and its checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module rre_exec_test;
  import rre_pkg::*;
  logic clk = 0, rst = 1, instr_valid = 0, carry_in = 0;
  logic [13:0] instr = 14'h0000;
  logic [12:0] stack_top_entry = 13'h1A5C, pc_value;
  logic [7:0]  file_rdata = 8'h00, file_wdata, w_value;
  logic [6:0]  file_addr;
  logic busy, done, stack_pop, pc_load, global_irq_enable_set, file_we, carry_we, carry_out, w_we;
  int errors = 0, num_checks = 0;
  rre_exec i_rre_exec
  (
    .clk                   (clk),
    .rst                   (rst),
    .instr_valid           (instr_valid),
    .instr                 (instr),
    .busy                  (busy),
    .done                  (done),
    .stack_top_entry       (stack_top_entry),
    .stack_pop             (stack_pop),
    .pc_load               (pc_load),
    .pc_value              (pc_value),
    .global_irq_enable_set (global_irq_enable_set),
    .file_addr             (file_addr),
    .file_rdata            (file_rdata),
    .file_we               (file_we),
    .file_wdata            (file_wdata),
    .carry_in              (carry_in),
    .carry_we              (carry_we),
    .carry_out             (carry_out),
    .w_value               (w_value),
    .w_we                  (w_we)
  );
  always #10 clk = ~clk;
  task chk(input string n, input logic [15:0] s, e);
    num_checks++;
    if (s !== e)
    begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task do_ret(input logic [13:0] op, input logic [12:0] top, input logic irq, wr);
    @(posedge clk);
    instr_valid <= 1;
    instr <= op;
    stack_top_entry <= top;
    @(posedge clk);
    instr_valid <= 0;
    #1;
    chk("ret", {stack_pop, pc_load, global_irq_enable_set, w_we}, {2'b11, irq, wr});
    chk("pc", pc_value, top);
    chk("busy1", {busy, done}, 16'h2);
    if (wr) chk("w", w_value, op[7:0]);
    @(posedge clk);
    #1 chk("done", {busy, done, stack_pop}, 16'h2);
  endtask : do_ret
  task do_refuse;
    @(posedge clk);
    instr_valid <= 1;
    instr <= 14'h3000;
    @(posedge clk);
    instr <= 14'h0008;
    #1 chk("none", {stack_pop, carry_we, w_we, file_we, done}, 16'h0);
    @(posedge clk);
    instr <= 14'h0D85;
    @(posedge clk);
    instr_valid <= 0;
    #1 chk("busy rot", {carry_we, file_we, done}, 16'h1);
  endtask : do_refuse
  task do_rot(input logic [13:0] op, input logic [7:0] rd, input logic c);
    @(posedge clk);
    instr_valid <= 1;
    instr <= op;
    file_rdata <= rd;
    carry_in <= c;
    @(posedge clk);
    instr_valid <= 0;
    #1;
    chk("rot", {done, carry_we, file_we, w_we}, {2'b11, op[7], !op[7]});
    chk("res", op[7] ? file_wdata : w_value, {rd[6:0], c});
    chk("c", carry_out, rd[7]);
    chk("addr", file_addr, op[6:0]);
  endtask : do_rot
  task finish_test;
    if (errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  initial
  begin
    #20000;
    errors++;
    finish_test;
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 0;
    do_ret(14'h0009, 13'h1A5C, 1, 0);
    do_ret(14'h34AA, 13'h0123, 0, 1);
    do_ret(14'h37FF, 13'h1FFF, 0, 1);
    do_ret(14'h0008, 13'h0ABC, 0, 0);
    do_rot(14'h0D05, 8'hE6, 0);
    do_rot(14'h0DFF, 8'h19, 1);
    do_refuse;
    finish_test;
  end
endmodule : rre_exec_test
`default_nettype wire
